//--- pkg/rcm_pkg.sv
// Constants, types and state encoding for the reset and clock monitor sequencer
package rcm_pkg;

    // Clock and timing figures, each time kept in its own unit
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned T_POR_US = 10;
    localparam int unsigned T_STARTUP_US = 20;
    localparam int unsigned T_RST_US = 20;
    localparam int unsigned T_PUT_MS = 64;
    localparam int unsigned T_MSD_US = 500;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned NS_PER_MS = 1000000;

    // Least times round up to whole clock cycles
    localparam int unsigned POR_CYC =
        (T_POR_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STARTUP_CYC =
        (T_STARTUP_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_CYC =
        (T_RST_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PUT_CYC =
        (T_PUT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MSD_CYC =
        (T_MSD_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SKIP_CYC = 1;

    // Delay counter must hold the power-up timer count
    localparam int unsigned TMR_W = 21;
    typedef logic [TMR_W-1:0] rcm_cnt_t;

    // Reset sources: index is also the flag position in the reset-cause register
    localparam int unsigned NUM_SRC = 8;
    localparam int unsigned SRC_POR = 0;
    localparam int unsigned SRC_BOR = 1;
    localparam int unsigned SRC_EXT = 2;
    localparam int unsigned SRC_WDT = 3;
    localparam int unsigned SRC_SW = 4;
    localparam int unsigned SRC_IOP = 5;
    localparam int unsigned SRC_UWR = 6;
    localparam int unsigned SRC_TRAP = 7;

    // Synchronised pin inputs: reset requests, then oscillator status
    localparam int unsigned SYN_OST = NUM_SRC;
    localparam int unsigned SYN_LOCK = NUM_SRC + 1;
    localparam int unsigned SYN_CLKOK = NUM_SRC + 2;
    localparam int unsigned SYN_W = NUM_SRC + 3;

    localparam int unsigned REG_W = 16;
    localparam logic [REG_W-1:0] CAUSE_POR_VAL = 16'h0003;

    // Oscillator control register layout
    localparam int unsigned OC_COSC_LSB = 12;
    localparam int unsigned OC_NOSC_LSB = 8;
    localparam int unsigned OC_CF_BIT = 3;
    localparam int unsigned OSC_SEL_W = 3;
    localparam logic [REG_W-1:0] OSC_CTRL_BASE_VAL = 16'h0000;

    // Oscillator selection codes in the oscillator configuration word
    localparam logic [OSC_SEL_W-1:0] OSC_IRC = 3'h0;
    localparam logic [OSC_SEL_W-1:0] OSC_IRCPLL = 3'h1;
    localparam logic [OSC_SEL_W-1:0] OSC_PRI = 3'h2;
    localparam logic [OSC_SEL_W-1:0] OSC_PRIPLL = 3'h3;
    localparam logic [OSC_SEL_W-1:0] OSC_SEC = 3'h4;

    // Primary oscillator mode: external clock or crystal
    localparam int unsigned PRI_MODE_W = 2;
    localparam logic [PRI_MODE_W-1:0] PRI_EC = 2'h0;

    // Gray coded along POR, startup, internal reset, monitor delay, monitor
    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_STARTUP = 3'h1,
        ST_INTRST = 3'h3,
        ST_MON_DELAY = 3'h2,
        ST_MONITOR = 3'h6,
        ST_RUN = 3'h7
    } rcm_state_e;

endpackage : rcm_pkg

//--- pkg/rcm_tmr_if.sv
// Load and expiry signals between the sequencer and its delay counter
`timescale 1ns/1ns
interface rcm_tmr_if;
    logic load;
    rcm_pkg::rcm_cnt_t count;
    logic done;

    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface : rcm_tmr_if

//--- logic/rcm_delay_counter.sv
// Down counter that times every reset and monitor delay
`timescale 1ns/1ns
module rcm_delay_counter #(
    parameter rcm_pkg::rcm_cnt_t RESET_COUNT = rcm_pkg::rcm_cnt_t'(rcm_pkg::POR_CYC)
) (
    input wire logic clk,
    input wire logic sys_rst,
    rcm_tmr_if.tmr tmr
);

    rcm_pkg::rcm_cnt_t cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // Reset loads the first delay so the power-on phase never ends at once
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt_r <= RESET_COUNT;
        end
        else if (tmr.load)
        begin
            cnt_r <= tmr.count;
        end
        else if (cnt_r != '0)
        begin
            cnt_r <= cnt_r - rcm_pkg::rcm_cnt_t'(1);
        end
    end

    assign tmr.done = (cnt_r == '0);

endmodule : rcm_delay_counter

//--- logic/rcm_reset_sequencer.sv
// Reset release sequencer with clock monitor start delay and reset-dependent registers
//
// Contract
// R1 - With a crystal or PLL system clock a monitor start delay is added after power-on and power-up timer delays.
// R2 - The fail-safe clock monitor does not check the clock until that delay has fully run out.
// R3 - The monitor start delay is nominally 500 microseconds.
// R4 - The delay also applies with the power-up timer disabled, so a reset raises no oscillator fail trap.
// R5 - Every other special function register loads one default value whatever the reset type.
// R6 - The reset-cause register value depends on which kind of reset happened.
// R7 - The oscillator control register value depends on reset type and configured oscillator.
// R8 - An enabled monitor that finds no valid clock switches the system clock to the internal RC.
// R9 - With the regulator disabled the power-up timer delay is nominally 64 ms.
// R10 - The monitor start delay is a counter on the internal clock with a parameter terminal count.
`timescale 1ns/1ns
module rcm_reset_sequencer #(
    parameter rcm_pkg::rcm_cnt_t PUT_COUNT = rcm_pkg::rcm_cnt_t'(rcm_pkg::PUT_CYC),
    parameter rcm_pkg::rcm_cnt_t MSD_COUNT = rcm_pkg::rcm_cnt_t'(rcm_pkg::MSD_CYC)
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [rcm_pkg::NUM_SRC-1:0] reset_req,
    input wire logic osc_ready,
    input wire logic pll_locked,
    input wire logic clock_valid,
    input wire logic [rcm_pkg::OSC_SEL_W-1:0] oscillator_config_word,
    input wire logic [rcm_pkg::PRI_MODE_W-1:0] pri_mode_cfg,
    input wire logic regulator_en,
    input wire logic power_up_timer_en,
    input wire logic monitor_en,
    output logic system_reset,
    output logic monitor_active,
    output logic rc_switch,
    output logic osc_fail_trap,
    output logic [rcm_pkg::REG_W-1:0] reset_cause_register,
    output logic [rcm_pkg::REG_W-1:0] oscillator_control_register
);

    localparam rcm_pkg::rcm_cnt_t POR_CNT = rcm_pkg::rcm_cnt_t'(rcm_pkg::POR_CYC);
    localparam rcm_pkg::rcm_cnt_t STARTUP_CNT = rcm_pkg::rcm_cnt_t'(rcm_pkg::STARTUP_CYC);
    localparam rcm_pkg::rcm_cnt_t RST_CNT = rcm_pkg::rcm_cnt_t'(rcm_pkg::RST_CYC);
    localparam rcm_pkg::rcm_cnt_t SKIP_CNT = rcm_pkg::rcm_cnt_t'(rcm_pkg::SKIP_CYC);

    rcm_tmr_if tmr_if ();

    logic [rcm_pkg::SYN_W-1:0] syn1_r;
    logic [rcm_pkg::SYN_W-1:0] syn2_r;
    logic [rcm_pkg::SYN_W-1:0] syn3_r;
    logic [rcm_pkg::SYN_W-1:0] flt_r;
    logic [rcm_pkg::SYN_W-1:0] flt_nxt;
    logic [rcm_pkg::SYN_W-1:0] pin_vec;

    rcm_pkg::rcm_state_e st_r;
    rcm_pkg::rcm_state_e st_nxt;
    logic [rcm_pkg::OSC_SEL_W-1:0] osc_sel_r;
    logic [rcm_pkg::PRI_MODE_W-1:0] pri_mode_r;
    logic reg_en_r;
    logic put_en_r;
    logic mon_en_r;
    logic [rcm_pkg::NUM_SRC-1:0] req;
    logic req_any;
    logic req_power;
    logic req_brown;
    logic xtal_or_pll;
    logic clk_fail;
    logic tmr_load;
    rcm_pkg::rcm_cnt_t tmr_count;
    rcm_pkg::rcm_cnt_t startup_count;
    logic [rcm_pkg::REG_W-1:0] cause_r;
    logic [rcm_pkg::REG_W-1:0] oscc_r;
    logic sysrst_r;
    logic mon_act_r;
    logic rc_sw_r;
    logic trap_r;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser: a level counts once stages two and three agree
    assign pin_vec = {clock_valid, pll_locked, osc_ready, reset_req};
    assign flt_nxt = (syn2_r & syn3_r) | (flt_r & (syn2_r ^ syn3_r));

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            syn1_r <= '0;
            syn2_r <= '0;
            syn3_r <= '0;
            flt_r <= '0;
        end
        else
        begin
            syn1_r <= pin_vec;
            syn2_r <= syn1_r;
            syn3_r <= syn2_r;
            flt_r <= flt_nxt;
        end
    end

    assign req = flt_r[rcm_pkg::NUM_SRC-1:0];
    assign req_any = |req;
    assign req_power = req[rcm_pkg::SRC_POR];
    assign req_brown = req[rcm_pkg::SRC_BOR];

    ////////////////////////////////////////////////////////////////////////////
    // Configuration straps are caught while a reset is in progress, never by reset
    always_ff @(posedge clk)
    begin
        if (req_any || st_r == rcm_pkg::ST_POR)
        begin
            osc_sel_r <= oscillator_config_word;
            pri_mode_r <= pri_mode_cfg;
            reg_en_r <= regulator_en;
            put_en_r <= power_up_timer_en;
            mon_en_r <= monitor_en;
        end
    end

    // Crystal or PLL sources need the extra settling time before monitoring
    always_comb
    begin
        case (osc_sel_r)
            rcm_pkg::OSC_IRCPLL: xtal_or_pll = 1'b1;
            rcm_pkg::OSC_PRIPLL: xtal_or_pll = 1'b1;
            rcm_pkg::OSC_SEC: xtal_or_pll = 1'b1;
            rcm_pkg::OSC_PRI: xtal_or_pll = (pri_mode_r != rcm_pkg::PRI_EC);
            default: xtal_or_pll = 1'b0;
        endcase
    end

    // Regulator on gives the short startup; off uses the power-up timer if enabled
    always_comb
    begin
        if (reg_en_r)
        begin
            startup_count = STARTUP_CNT;
        end
        else if (put_en_r)
        begin
            startup_count = PUT_COUNT; // see R9
        end
        else
        begin
            startup_count = SKIP_CNT;
        end
    end

    // A clock is judged failed when the selected source is not running
    assign clk_fail = !flt_r[rcm_pkg::SYN_CLKOK] ||
        (xtal_or_pll && !flt_r[rcm_pkg::SYN_OST] && osc_sel_r != rcm_pkg::OSC_IRCPLL) ||
        ((osc_sel_r == rcm_pkg::OSC_IRCPLL || osc_sel_r == rcm_pkg::OSC_PRIPLL) &&
         !flt_r[rcm_pkg::SYN_LOCK]);

    ////////////////////////////////////////////////////////////////////////////
    // Sequence: power-on, startup, internal reset, monitor delay, monitor
    always_comb
    begin
        st_nxt = st_r;
        tmr_load = 1'b0;
        tmr_count = SKIP_CNT;
        if (req_any)
        begin
            // A held request keeps reloading, so timing starts at its release
            tmr_load = 1'b1;
            if (req_power)
            begin
                st_nxt = rcm_pkg::ST_POR;
                tmr_count = POR_CNT;
            end
            else if (req_brown)
            begin
                st_nxt = rcm_pkg::ST_STARTUP;
                tmr_count = startup_count;
            end
            else
            begin
                st_nxt = rcm_pkg::ST_INTRST;
                tmr_count = RST_CNT;
            end
        end
        else if (tmr_if.done)
        begin
            case (st_r)
                rcm_pkg::ST_POR:
                begin
                    st_nxt = rcm_pkg::ST_STARTUP;
                    tmr_load = 1'b1;
                    tmr_count = startup_count;
                end
                rcm_pkg::ST_STARTUP:
                begin
                    st_nxt = rcm_pkg::ST_INTRST;
                    tmr_load = 1'b1;
                    tmr_count = RST_CNT;
                end
                rcm_pkg::ST_INTRST:
                begin
                    if (xtal_or_pll)
                    begin
                        st_nxt = rcm_pkg::ST_MON_DELAY; // see R1
                        tmr_load = 1'b1;
                        tmr_count = MSD_COUNT; // see R3 see R4 see R10
                    end
                    else
                    begin
                        st_nxt = mon_en_r ? rcm_pkg::ST_MONITOR : rcm_pkg::ST_RUN;
                    end
                end
                rcm_pkg::ST_MON_DELAY:
                begin
                    st_nxt = mon_en_r ? rcm_pkg::ST_MONITOR : rcm_pkg::ST_RUN; // see R2
                end
                rcm_pkg::ST_MONITOR: st_nxt = rcm_pkg::ST_MONITOR;
                rcm_pkg::ST_RUN: st_nxt = rcm_pkg::ST_RUN;
                default: st_nxt = rcm_pkg::ST_POR;
            endcase
        end
    end

    assign tmr_if.load = tmr_load;
    assign tmr_if.count = tmr_count;

    rcm_delay_counter #(
        .RESET_COUNT(POR_CNT)
    ) u_delay (
        .clk(clk),
        .sys_rst(sys_rst),
        .tmr(tmr_if.tmr)
    );

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r <= rcm_pkg::ST_POR;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System reset and monitor status; other registers hold defaults while reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sysrst_r <= 1'b1;
            mon_act_r <= 1'b0;
        end
        else
        begin
            sysrst_r <= (st_nxt == rcm_pkg::ST_POR || st_nxt == rcm_pkg::ST_STARTUP ||
                st_nxt == rcm_pkg::ST_INTRST); // see R5
            mon_act_r <= (st_nxt == rcm_pkg::ST_MONITOR); // see R2
        end
    end

    // First check after the delay and every cycle after it may trip the switch
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rc_sw_r <= 1'b0;
            trap_r <= 1'b0;
        end
        else if (req_any)
        begin
            rc_sw_r <= 1'b0;
            trap_r <= 1'b0;
        end
        else
        begin
            trap_r <= mon_act_r && clk_fail && !rc_sw_r;
            if (mon_act_r && clk_fail)
            begin
                rc_sw_r <= 1'b1; // see R8
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset-cause flags: power-on loads a fixed value, others add their flag
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cause_r <= rcm_pkg::CAUSE_POR_VAL;
        end
        else if (req_power)
        begin
            cause_r <= rcm_pkg::CAUSE_POR_VAL; // see R6
        end
        else if (req_any)
        begin
            cause_r <= cause_r |
                {{(rcm_pkg::REG_W - rcm_pkg::NUM_SRC){1'b0}}, req}; // see R6
        end
    end

    // Power resets take the configured oscillator; others keep the running one
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            oscc_r <= rcm_pkg::OSC_CTRL_BASE_VAL;
        end
        else if (req_power || req_brown)
        begin
            oscc_r <= rcm_pkg::OSC_CTRL_BASE_VAL;
            oscc_r[rcm_pkg::OC_COSC_LSB +: rcm_pkg::OSC_SEL_W] <= osc_sel_r; // see R7
            oscc_r[rcm_pkg::OC_NOSC_LSB +: rcm_pkg::OSC_SEL_W] <= osc_sel_r; // see R7
        end
        else if (req_any)
        begin
            oscc_r[rcm_pkg::OC_NOSC_LSB +: rcm_pkg::OSC_SEL_W] <= osc_sel_r; // see R7
        end
        else if (st_r == rcm_pkg::ST_POR && tmr_if.done)
        begin
            // A power-on from sys_rst has no request pin, so the strap lands as it ends
            oscc_r[rcm_pkg::OC_COSC_LSB +: rcm_pkg::OSC_SEL_W] <= osc_sel_r; // see R7
            oscc_r[rcm_pkg::OC_NOSC_LSB +: rcm_pkg::OSC_SEL_W] <= osc_sel_r; // see R7
        end
        else if (mon_act_r && clk_fail)
        begin
            oscc_r[rcm_pkg::OC_COSC_LSB +: rcm_pkg::OSC_SEL_W] <= rcm_pkg::OSC_IRC; // see R8
            oscc_r[rcm_pkg::OC_CF_BIT] <= 1'b1;
        end
    end

    assign system_reset = sysrst_r;
    assign monitor_active = mon_act_r;
    assign rc_switch = rc_sw_r;
    assign osc_fail_trap = trap_r;
    assign reset_cause_register = cause_r;
    assign oscillator_control_register = oscc_r;

endmodule : rcm_reset_sequencer

//--- tb/rcm_osc_model.sv
// Behavioural oscillator and PLL standing in front of the sequencer
`timescale 1ns/1ns
module rcm_osc_model #(
    parameter int START_CYC = 64,
    parameter int LOCK_CYC = 16
) (
    input wire logic clk,
    input wire logic fail,
    output logic osc_ready,
    output logic pll_locked,
    output logic clock_valid
);
    int run_r;

    // A failed oscillator must start up and relock from scratch
    always_ff @(posedge clk)
    begin
        if (fail)
            run_r <= 0;
        else if (run_r < START_CYC + LOCK_CYC)
            run_r <= run_r + 1;
    end
    assign osc_ready = !fail && run_r >= START_CYC;
    assign pll_locked = !fail && run_r >= START_CYC + LOCK_CYC;
    assign clock_valid = !fail;
endmodule : rcm_osc_model

//--- tb/rcm_seq_monitor.sv
// Concurrent checks on the reset sequencer ports
`timescale 1ns/1ns
module rcm_seq_monitor #(
    parameter rcm_pkg::rcm_cnt_t MSD_COUNT = rcm_pkg::rcm_cnt_t'(rcm_pkg::MSD_CYC)
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clock_valid,
    input wire logic [2:0] oscillator_config_word,
    input wire logic [1:0] pri_mode_cfg,
    input wire logic system_reset,
    input wire logic monitor_active,
    input wire logic rc_switch,
    input wire logic osc_fail_trap,
    input wire logic [15:0] reset_cause_register,
    input wire logic [15:0] oscillator_control_register
);
    int free_r;
    logic slow_src;

    // Crystal and PLL sources are the ones that need settling time
    assign slow_src = oscillator_config_word inside {rcm_pkg::OSC_IRCPLL, rcm_pkg::OSC_PRIPLL,
        rcm_pkg::OSC_SEC} || (oscillator_config_word == rcm_pkg::OSC_PRI
        && pri_mode_cfg != rcm_pkg::PRI_EC);

    // Cycles since reset release, saturating so it never wraps
    always_ff @(posedge clk)
    begin
        if (sys_rst || system_reset)
            free_r <= 0;
        else if (free_r < 100000)
            free_r <= free_r + 1;
    end

    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////
    rst_vals_a: assert property ($fell(sys_rst) |-> system_reset && !rc_switch
        && reset_cause_register == 16'h0003 && oscillator_control_register == 16'h0000)
        else $error("reset values wrong");
    mon_gate_a: assert property (monitor_active |-> !system_reset)
        else $error("monitor active in reset");
    slow_min_a: assert property ($rose(monitor_active) && slow_src
        |-> free_r >= MSD_COUNT - 1) else $error("monitor started early");
    slow_max_a: assert property ($rose(monitor_active) && slow_src
        |-> free_r <= MSD_COUNT + 4) else $error("monitor started late");
    fast_src_a: assert property ($rose(monitor_active) && !slow_src |-> free_r <= 3)
        else $error("delay on non crystal source");
    fail_frc_a: assert property ($fell(clock_valid) && monitor_active
        |-> ##[1:6] (rc_switch || system_reset)) else $error("no switch to rc");
    trap_rise_a: assert property ($rose(rc_switch)
        |-> osc_fail_trap && $past(monitor_active)) else $error("switch without trap");
    fail_ctrl_a: assert property (rc_switch
        |-> oscillator_control_register[rcm_pkg::OC_COSC_LSB +: 3] == rcm_pkg::OSC_IRC
        && oscillator_control_register[rcm_pkg::OC_CF_BIT]) else $error("ctrl after fail");
    sw_clear_a: assert property (system_reset && $past(system_reset) |-> !rc_switch)
        else $error("switch kept in reset");

    cover property ($rose(monitor_active));
    cover property ($rose(rc_switch));
    cover property ($rose(system_reset));
endmodule : rcm_seq_monitor

bind rcm_reset_sequencer rcm_seq_monitor #(.MSD_COUNT(MSD_COUNT)) u_rcm_mon (
    .clk(clk), .sys_rst(sys_rst), .clock_valid(clock_valid),
    .oscillator_config_word(oscillator_config_word), .pri_mode_cfg(pri_mode_cfg),
    .system_reset(system_reset), .monitor_active(monitor_active), .rc_switch(rc_switch),
    .osc_fail_trap(osc_fail_trap), .reset_cause_register(reset_cause_register),
    .oscillator_control_register(oscillator_control_register)
);

//--- tb/tb_top.sv
// Self-checking bench for the reset and clock monitor sequencer
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
////////////////////////////////////////
module tb_top;
    // Short counts keep the run brief; expectations follow them
    localparam int PUT_N = 20;
    localparam int MSD_N = 30;
    localparam int POR_N = rcm_pkg::POR_CYC;
    localparam int RST_N = rcm_pkg::RST_CYC;
    int n_fail = 0;
    int compares = 0;
    logic clk;
    logic sys_rst = 1'b1;
    logic fail = 1'b0;
    logic [7:0] req = 8'h00;
    logic [2:0] cfg = 3'h2;
    logic [1:0] mode = 2'h1;
    logic reg_en = 1'b1;
    logic put_en = 1'b1;
    logic osc_ok, lock, clk_ok, rst_o, mon_o, rcsw_o, trap_o;
    logic [15:0] cause_o;
    logic [15:0] osc_o;

    rcm_reset_sequencer #(.PUT_COUNT(rcm_pkg::rcm_cnt_t'(PUT_N)),
        .MSD_COUNT(rcm_pkg::rcm_cnt_t'(MSD_N))) u_dut (
        .clk(clk), .sys_rst(sys_rst), .reset_req(req), .osc_ready(osc_ok),
        .pll_locked(lock), .clock_valid(clk_ok), .oscillator_config_word(cfg),
        .pri_mode_cfg(mode), .regulator_en(reg_en), .power_up_timer_en(put_en),
        .monitor_en(1'b1), .system_reset(rst_o), .monitor_active(mon_o),
        .rc_switch(rcsw_o), .osc_fail_trap(trap_o), .reset_cause_register(cause_o),
        .oscillator_control_register(osc_o));
    rcm_osc_model u_osc (.clk(clk), .fail(fail), .osc_ready(osc_ok), .pll_locked(lock),
        .clock_valid(clk_ok));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////
    task automatic wait_sig(input bit mon, input logic val, output int n);
        n = 0;
        while (((mon ? mon_o : rst_o) !== val) && n < 3000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_sig

    // Straps change only inside reset, since they are captured there
    task automatic run_power(input logic [2:0] c, input logic [1:0] m, input logic r,
        input logic p, input int st, input bit slow);
        int n;
        @(posedge clk);
        #1;
        sys_rst = 1'b1;
        cfg = c;
        mode = m;
        reg_en = r;
        put_en = p;
        repeat (8) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        @(posedge clk);
        #1;
        `CHK({rst_o, cause_o, osc_o}, {1'b1, 16'h0003, 16'h0000})
        wait_sig(1'b0, 1'b0, n);
        `CHK(n >= POR_N + st + RST_N - 2 && n <= POR_N + st + RST_N + 8, 1'b1)
        `CHK(osc_o, {1'b0, c, 1'b0, c, 8'h00})
        wait_sig(1'b1, 1'b1, n);
        `CHK(slow ? (n >= MSD_N - 1 && n <= MSD_N + 4) : (n <= 3), 1'b1)
    endtask : run_power

    task automatic t_fail();
        int n;
        bit seen;
        n = 0;
        seen = 1'b0;
        fail = 1'b1;
        while (rcsw_o !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
            seen |= (trap_o === 1'b1);
        end
        `CHK({rcsw_o, seen, osc_o}, {2'b11, 16'h0208})
        @(posedge clk);
        #1;
        `CHK({rcsw_o, trap_o}, 2'b10)
        fail = 1'b0;
    endtask : t_fail

    task automatic t_src(input int s, input logic [15:0] cs, input logic [15:0] oc,
        input int rel);
        int n;
        req[s] = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        `CHK({rst_o, rcsw_o, mon_o}, 3'b100)
        req[s] = 1'b0;
        wait_sig(1'b0, 1'b0, n);
        `CHK(n >= rel && n <= rel + 8, 1'b1)
        `CHK({cause_o, osc_o}, {cs, oc})
    endtask : t_src

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////
    initial
    begin
        logic [15:0] c;
        run_power(rcm_pkg::OSC_IRC, 2'h1, 1'b1, 1'b1, 500, 1'b0);
        run_power(rcm_pkg::OSC_PRI, 2'h0, 1'b0, 1'b1, PUT_N, 1'b0);
        run_power(rcm_pkg::OSC_PRIPLL, 2'h1, 1'b0, 1'b0, 1, 1'b1);
        run_power(rcm_pkg::OSC_IRCPLL, 2'h1, 1'b1, 1'b1, 500, 1'b1);
        run_power(rcm_pkg::OSC_SEC, 2'h1, 1'b1, 1'b1, 500, 1'b1);
        run_power(rcm_pkg::OSC_PRI, 2'h1, 1'b1, 1'b1, 500, 1'b1);
        t_fail();
        c = 16'h0003;
        for (int s = 2; s < 8; s++)
        begin
            c[s] = 1'b1;
            t_src(s, c, 16'h0208, RST_N);
        end
        t_src(1, 16'h00FF, 16'h2200, 500 + RST_N);
        finish_test();
    end

    // About 11000 cycles are needed; allow 30000 before giving up
    initial
    begin
        #(30000 * 40);
        n_fail++;
        finish_test();
    end
endmodule : tb_top
